// *** sim/rsc_top_asserts.sv ***
module rsc_chk (
  input logic clk, rst_b, reg_wr, reg_rd, unlock_ok, strobe_valid, system_supply_output,
  input logic [7:0] reg_addr, reg_wdata,
  input logic [3:0] strobe_step, rail_enable_pulse,
  input rsc_pkg::rsc_byte_t reg_rdata,
  input rsc_pkg::rsc_level_t undervoltage_lockout_level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire [1:0] lvl = undervoltage_lockout_level;
  wire top = strobe_valid && strobe_step == 4'hF;
  sys_on_a: assert property (top |=> system_supply_output) else $error("sys");
  sys_off_a: assert property (!top |=> !system_supply_output) else $error("sys");
  undervoltage_lockout_level_rd_a: assert property (reg_rd && reg_addr == 8'h18
    |=> reg_rdata[7:3] == 5'h00 && reg_rdata[1:0] == $past(lvl)) else $error("rd");
  slot_one_a: assert property (reg_rd && reg_addr == 8'h19
    |=> (reg_rdata & 8'h88) == 8'h00) else $error("rd");
  slot_two_a: assert property (reg_rd && reg_addr == 8'h1A
    |=> !reg_rdata[7]) else $error("rd");
  lock_a: assert property (reg_wr && !unlock_ok |=> $stable(lvl)) else $error("lock");
  lvl_wr_a: assert property (reg_wr && unlock_ok && reg_addr == 8'h18
    |=> lvl == 2'($past(reg_wdata))) else $error("wr");
  idle_a: assert property (!strobe_valid |=> rail_enable_pulse == 4'h0) else $error("pulse");
  cover property (top);
  cover property (reg_wr && unlock_ok);
  cover property (reg_wr && !unlock_ok);
endmodule
bind rsc_top rsc_chk rsc_chk_i (.*);

// *** sim/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, unlock_ok = 1'h0;
  logic strobe_valid = 1'h0, system_supply_output;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] strobe_step = 4'h0, rail_enable_pulse, rail_controlled;
  logic [1:0] undervoltage_lockout_level;
  int err_total = 0, n_compared = 0;
  always #10 clk = ~clk;
  rsc_top rsc_top_i (.*);
  task chk(logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: %h not %h", $time, g, e);
    end
  endtask
  // Inputs move on the falling edge so no race with the sampling edge.
  task wr(logic [7:0] a, d, logic u);
    @(negedge clk);
    {reg_addr, reg_wdata, unlock_ok, reg_wr} = {a, d, u, 1'h1};
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task rd(logic [7:0] a, e);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'h1};
    @(negedge clk);
    reg_rd = 1'h0;
    chk(reg_rdata, e);
  endtask
  task stp(logic [3:0] s, e, logic y);
    @(negedge clk);
    {strobe_step, strobe_valid} = {s, 1'h1};
    @(negedge clk);
    strobe_valid = 1'h0;
    chk({3'h0, system_supply_output, rail_enable_pulse}, {3'h0, y, e});
  endtask
  task defaults;
    rd(8'h18, 8'h03);
    rd(8'h19, 8'h15);
    rd(8'h1A, 8'h5F);
    rd(8'h1B, 8'h00);
  endtask
  task locked;
    wr(8'h18, 8'hFC, 1'h0);
    rd(8'h18, 8'h03);
    chk({6'h00, undervoltage_lockout_level}, 8'h03);
  endtask
  task layout;
    wr(8'h18, 8'hFE, 1'h1);
    rd(8'h18, 8'h06);
    chk({6'h00, undervoltage_lockout_level}, 8'h02);
    wr(8'h19, 8'hFF, 1'h1);
    rd(8'h19, 8'h77);
  endtask
  task strobes;
    wr(8'h19, 8'h30, 1'h1);
    wr(8'h1A, 8'h79, 1'h1);
    stp(4'h3, 4'h1, 1'h0);
    stp(4'h9, 4'h0, 1'h0);
    chk({4'h0, rail_controlled}, 8'h05);
    wr(8'h1A, 8'h0E, 1'h1);
    stp(4'hE, 4'h8, 1'h0);
    wr(8'h1A, 8'h0F, 1'h1);
    stp(4'hF, 4'h8, 1'h1);
  endtask
  task summarize;
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'h1;
    repeat (3) @(negedge clk);
    defaults();
    locked();
    layout();
    strobes();
    summarize();
  end
endmodule

// *** src/rsc_map.svh ***
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL 8'h18
`define RSC_ADDR_SLOT1 8'h19
`define RSC_ADDR_SLOT2 8'h1A
`define RSC_UNDERVOLTAGE_LOCKOUT_LEVEL_RESET 8'h03
`define RSC_UNDERVOLTAGE_LOCKOUT_LEVEL_LEVEL_LSB 0
`define RSC_UNDERVOLTAGE_LOCKOUT_LEVEL_SPARE_BIT 2
`define RSC_BUCK1_LSB 4
`define RSC_BUCK2_LSB 0
`define RSC_BUCK3_LSB 4
`define RSC_LIN1_LSB 0
`define RSC_BUCK1_RESET 3'h1
`define RSC_BUCK2_RESET 3'h5
`define RSC_BUCK3_RESET 3'h5
`define RSC_LIN1_RESET 4'hF
`define RSC_LIN_OFF_A 4'h8
`define RSC_LIN_OFF_B 4'h9
`define RSC_LIN_STEP14 4'hE
`define RSC_LIN_STEP15 4'hF
`endif

// *** src/rsc_pkg.sv ***
package rsc_pkg;
  typedef logic [7:0] rsc_byte_t;
  typedef logic [2:0] rsc_slot3_t;
  typedef logic [3:0] rsc_slot4_t;
  typedef logic [3:0] rsc_step_t;
  typedef logic [1:0] rsc_level_t;
endpackage

// *** src/rsc_slot_match.sv ***
`include "rsc_map.svh"
// Compares one slot field against the current strobe step.
module rsc_slot_match #(
  parameter int WIDTH = 3
) (
  input wire logic [WIDTH-1:0] slot,
  input wire logic [3:0] step,
  input wire logic step_valid,
  output logic hit,
  output logic controlled
);
  import rsc_pkg::*;
  logic [3:0] slot_wide;
  always_comb begin
    slot_wide = 4'h0;
    slot_wide[WIDTH-1:0] = slot;
    // Zero, and on the four-bit field the two parked codes, stay out of sequencing.
    controlled = (slot_wide != 4'h0) && (slot_wide != `RSC_LIN_OFF_A)
      && (slot_wide != `RSC_LIN_OFF_B);
    // Codes 1..7 and 10..15 fire on the strobe step of the same number.
    hit = controlled && step_valid && (slot_wide == step);
  end
endmodule

// *** src/rsc_top.sv ***
// Notes on behaviour
// - Threshold register bits 1:0 pick 2.73/2.89/3.18/3.3 V; resets to 0x03.
// - Threshold and slot writes land only while the password unlock holds.
// - Threshold bits 7:3 read zero; bit 2 is a spare read/write bit, reset zero.
// - A zero slot keeps the rail out of sequencer control entirely.
// - Slot values one to seven enable the rail at that strobe step.
// - First slot register: buck one in 6:4, buck two in 2:0, 7 and 3 zero.
// - Second slot register: buck three in 6:4, linear one in 3:0, bit 7 zero.
// - Linear one codes 1000b and 1001b also leave the rail uncontrolled.
// - Linear one code 1110b enables the rail at strobe step fourteen.
// - Linear one code 1111b enables it at step fifteen with the system supply.
`include "rsc_map.svh"
module rsc_top #(
  parameter logic [2:0] BUCK1_RESET = `RSC_BUCK1_RESET,
  parameter logic [2:0] BUCK2_RESET = `RSC_BUCK2_RESET,
  parameter logic [2:0] BUCK3_RESET = `RSC_BUCK3_RESET,
  parameter logic [3:0] LIN1_RESET = `RSC_LIN1_RESET
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic unlock_ok,
  input wire logic [3:0] strobe_step,
  input wire logic strobe_valid,
  output rsc_pkg::rsc_byte_t reg_rdata,
  output rsc_pkg::rsc_level_t undervoltage_lockout_level,
  output logic [3:0] rail_enable_pulse,
  output logic [3:0] rail_controlled,
  output logic system_supply_output
);
  import rsc_pkg::*;
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  rsc_level_t level_reg, level_next;
  logic spare_reg, spare_next;
  rsc_slot3_t buck_one_slot_reg, buck_one_slot_next;
  rsc_slot3_t buck_two_slot_reg, buck_two_slot_next;
  rsc_slot3_t buck_three_slot_reg, buck_three_slot_next;
  rsc_slot4_t linear_one_slot_reg, linear_one_slot_next;
  rsc_byte_t rdata_reg, rdata_next;
  logic [3:0] hit;
  logic [3:0] ctl;
  logic [3:0] pulse_reg;
  logic [3:0] ctl_reg;
  logic sys_reg;
  logic wr_ok;

  // Locked writes are dropped silently, as the serial interface has no error reply.
  assign wr_ok = reg_wr && unlock_ok;

  always_comb begin
    level_next = level_reg;
    spare_next = spare_reg;
    buck_one_slot_next = buck_one_slot_reg;
    buck_two_slot_next = buck_two_slot_reg;
    buck_three_slot_next = buck_three_slot_reg;
    linear_one_slot_next = linear_one_slot_reg;
    rdata_next = rdata_reg;
    if (wr_ok) begin
      unique case (reg_addr)
        `RSC_ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL: begin
          level_next = reg_wdata[`RSC_UNDERVOLTAGE_LOCKOUT_LEVEL_LEVEL_LSB +: 2];
          spare_next = reg_wdata[`RSC_UNDERVOLTAGE_LOCKOUT_LEVEL_SPARE_BIT];
        end
        `RSC_ADDR_SLOT1: begin
          buck_one_slot_next = reg_wdata[`RSC_BUCK1_LSB +: 3];
          buck_two_slot_next = reg_wdata[`RSC_BUCK2_LSB +: 3];
        end
        `RSC_ADDR_SLOT2: begin
          buck_three_slot_next = reg_wdata[`RSC_BUCK3_LSB +: 3];
          // Reserved codes are stored as written; software keeps clear of them.
          linear_one_slot_next = reg_wdata[`RSC_LIN1_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `RSC_ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL: rdata_next = {5'h00, spare_reg, level_reg};
        `RSC_ADDR_SLOT1: rdata_next = {1'b0, buck_one_slot_reg, 1'b0, buck_two_slot_reg};
        `RSC_ADDR_SLOT2: rdata_next = {1'b0, buck_three_slot_reg, linear_one_slot_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      level_reg <= 2'h3;
      spare_reg <= 1'b0;
      buck_one_slot_reg <= BUCK1_RESET;
      buck_two_slot_reg <= BUCK2_RESET;
      buck_three_slot_reg <= BUCK3_RESET;
      linear_one_slot_reg <= LIN1_RESET;
      rdata_reg <= 8'h00;
    end else begin
      level_reg <= level_next;
      spare_reg <= spare_next;
      buck_one_slot_reg <= buck_one_slot_next;
      buck_two_slot_reg <= buck_two_slot_next;
      buck_three_slot_reg <= buck_three_slot_next;
      linear_one_slot_reg <= linear_one_slot_next;
      rdata_reg <= rdata_next;
    end
  end

  rsc_slot_match #(.WIDTH(3)) u_buck1 (
    .slot(buck_one_slot_reg), .step(strobe_step), .step_valid(strobe_valid),
    .hit(hit[0]), .controlled(ctl[0]));
  rsc_slot_match #(.WIDTH(3)) u_buck2 (
    .slot(buck_two_slot_reg), .step(strobe_step), .step_valid(strobe_valid),
    .hit(hit[1]), .controlled(ctl[1]));
  rsc_slot_match #(.WIDTH(3)) u_buck3 (
    .slot(buck_three_slot_reg), .step(strobe_step), .step_valid(strobe_valid),
    .hit(hit[2]), .controlled(ctl[2]));
  rsc_slot_match #(.WIDTH(4)) u_lin1 (
    .slot(linear_one_slot_reg), .step(strobe_step), .step_valid(strobe_valid),
    .hit(hit[3]), .controlled(ctl[3]));

  // Outputs are registered so the sequencer engine sees glitch-free enables.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pulse_reg <= 4'h0;
      ctl_reg <= 4'h0;
      sys_reg <= 1'b0;
    end else begin
      pulse_reg <= hit;
      ctl_reg <= ctl;
      sys_reg <= strobe_valid && (strobe_step == `RSC_LIN_STEP15);
    end
  end

  assign reg_rdata = rdata_reg;
  assign undervoltage_lockout_level = level_reg;
  assign rail_enable_pulse = pulse_reg;
  assign rail_controlled = ctl_reg;
  assign system_supply_output = sys_reg;
endmodule
